// File: rtl/orbt_pkg.sv
`default_nettype none

package orbt_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned BUS_W = 8;
  localparam int unsigned AXI_AW = 4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [AXI_AW-1:0] CTRL_OFS = 4'h0;
  localparam logic [AXI_AW-1:0] STORE_OFS = 4'h4;
  localparam logic [AXI_AW-1:0] LIVE_OFS = 4'h8;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CTRL_OE_N_BIT = 0;
  localparam int unsigned CTRL_DIR_BIT = 1;
  localparam int unsigned CTRL_A2B_SEL_BIT = 2;
  localparam int unsigned CTRL_B2A_SEL_BIT = 3;
  localparam int unsigned STORE_A2B_LSB = 0;
  localparam int unsigned STORE_B2A_LSB = 16;
  localparam int unsigned STORE_DRV_A_BIT = 30;
  localparam int unsigned STORE_DRV_B_BIT = 31;
  localparam int unsigned LIVE_A_LSB = 0;
  localparam int unsigned LIVE_B_LSB = 16;

  // ****************************************
  // reset values and responses
  // ****************************************
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam logic [BUS_W-1:0] STORE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: rtl/orbt_sync.sv
`default_nettype none

module orbt_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import orbt_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } orbt_sync_state_t;

  orbt_sync_state_t st_r;
  orbt_sync_state_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

`default_nettype wire

// File: rtl/orbt_xcvr.sv
// Operation
// - store only on rising capture clock edge
// - two independent stores, each own clock
// - a_to_b clock rise stores A lines
// - b_to_a clock rise stores B lines
// - disabled outputs: neither bus driven, capture continues
// - direction matters only while output enabled
// - drive A with live B data
// - drive A from b_to_a store
// - drive B with live A data
// - drive B from a_to_b store
// - capture stays enabled when outputs disabled
// - non-driven port may load either store
// - never drive both buses at once
// - eight-bit two-way lines per side
`default_nettype none

module orbt_xcvr #(
  parameter int unsigned W = orbt_pkg::BUS_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [orbt_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [orbt_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  input wire logic [W-1:0] port_a_lines_i,
  output logic [W-1:0] port_a_lines_o,
  output logic [W-1:0] port_a_lines_oe,
  input wire logic [W-1:0] port_b_lines_i,
  output logic [W-1:0] port_b_lines_o,
  output logic [W-1:0] port_b_lines_oe
);
  import orbt_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [W-1:0] a2b_store;
    logic [W-1:0] b2a_store;
    logic oe_n;
    logic dir;
    logic a2b_sel;
    logic b2a_sel;
    logic a2b_prev;
    logic b2a_prev;
    logic [W-1:0] a_out;
    logic [W-1:0] b_out;
    logic a_drv;
    logic b_drv;
    logic aw_have;
    logic w_have;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } orbt_state_t;

  orbt_state_t st_r;
  orbt_state_t st_nxt;

  logic [W-1:0] a_live;
  logic [W-1:0] b_live;
  logic [1:0] cap_clk_s;
  logic rise_a2b;
  logic rise_b2a;
  logic drive_a;
  logic drive_b;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // lines and capture clocks share equal latency, so data and edge stay aligned
  orbt_sync #(.W(W)) u_sync_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(port_a_lines_i),
    .q(a_live)
  );

  orbt_sync #(.W(W)) u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(port_b_lines_i),
    .q(b_live)
  );

  orbt_sync #(.W(2)) u_sync_clk (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({b_to_a_capture_clock, a_to_b_capture_clock}),
    .q(cap_clk_s)
  );

  // ****************************************
  // capture edges and drive selection
  // ****************************************
  assign rise_a2b = cap_clk_s[0] & ~st_r.a2b_prev;
  assign rise_b2a = cap_clk_s[1] & ~st_r.b2a_prev;
  // direction only counts while enabled, so at most one bus is driven
  assign drive_a = ~st_r.oe_n & ~st_r.dir;
  assign drive_b = ~st_r.oe_n & st_r.dir;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.a2b_prev = cap_clk_s[0];
    st_nxt.b2a_prev = cap_clk_s[1];

    // capture ignores enable, direction and selects
    if (rise_a2b) begin
      st_nxt.a2b_store = a_live;
    end
    if (rise_b2a) begin
      st_nxt.b2a_store = b_live;
    end

    st_nxt.a_drv = drive_a;
    st_nxt.b_drv = drive_b;
    if (st_r.b2a_sel) begin
      st_nxt.a_out = st_r.b2a_store;
    end else begin
      st_nxt.a_out = b_live;
    end
    if (st_r.a2b_sel) begin
      st_nxt.b_out = st_r.a2b_store;
    end else begin
      st_nxt.b_out = a_live;
    end

    // write channel: address and data taken in either order
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (st_r.awaddr[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
        st_nxt.bresp = RESP_OKAY;
        if (st_r.wstrb[0]) begin
          st_nxt.oe_n = st_r.wdata[CTRL_OE_N_BIT];
          st_nxt.dir = st_r.wdata[CTRL_DIR_BIT];
          st_nxt.a2b_sel = st_r.wdata[CTRL_A2B_SEL_BIT];
          st_nxt.b2a_sel = st_r.wdata[CTRL_B2A_SEL_BIT];
        end
      end else if (st_r.awaddr[AXI_AW-1:2] == STORE_OFS[AXI_AW-1:2]) begin
        st_nxt.bresp = RESP_OKAY;
      end else if (st_r.awaddr[AXI_AW-1:2] == LIVE_OFS[AXI_AW-1:2]) begin
        st_nxt.bresp = RESP_OKAY;
      end else begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = '0;
      st_nxt.rresp = RESP_OKAY;
      if (s_axi_araddr[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
        st_nxt.rdata[CTRL_OE_N_BIT] = st_r.oe_n;
        st_nxt.rdata[CTRL_DIR_BIT] = st_r.dir;
        st_nxt.rdata[CTRL_A2B_SEL_BIT] = st_r.a2b_sel;
        st_nxt.rdata[CTRL_B2A_SEL_BIT] = st_r.b2a_sel;
      end else if (s_axi_araddr[AXI_AW-1:2] == STORE_OFS[AXI_AW-1:2]) begin
        st_nxt.rdata[STORE_A2B_LSB +: W] = st_r.a2b_store;
        st_nxt.rdata[STORE_B2A_LSB +: W] = st_r.b2a_store;
        st_nxt.rdata[STORE_DRV_A_BIT] = st_r.a_drv;
        st_nxt.rdata[STORE_DRV_B_BIT] = st_r.b_drv;
      end else if (s_axi_araddr[AXI_AW-1:2] == LIVE_OFS[AXI_AW-1:2]) begin
        st_nxt.rdata[LIVE_A_LSB +: W] = a_live;
        st_nxt.rdata[LIVE_B_LSB +: W] = b_live;
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.a2b_store <= STORE_RESET;
      st_r.b2a_store <= STORE_RESET;
      st_r.oe_n <= CTRL_RESET[CTRL_OE_N_BIT];
      st_r.dir <= CTRL_RESET[CTRL_DIR_BIT];
      st_r.a2b_sel <= CTRL_RESET[CTRL_A2B_SEL_BIT];
      st_r.b2a_sel <= CTRL_RESET[CTRL_B2A_SEL_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = ~st_r.aw_have & ~st_r.bvalid;
  assign s_axi_wready = ~st_r.w_have & ~st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign port_a_lines_o = st_r.a_out;
  assign port_b_lines_o = st_r.b_out;
  // every line has its own enable, all following the side's drive flag
  assign port_a_lines_oe = {W{st_r.a_drv}};
  assign port_b_lines_oe = {W{st_r.b_drv}};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_a2b_rise;
    rise_a2b;
  endsequence

  sequence s_isolated_rise;
    st_r.oe_n && rise_a2b && rise_b2a;
  endsequence

  sequence s_drive_b_both_rise;
    drive_b && rise_a2b && rise_b2a;
  endsequence

  property p_a2b_hold;
    !rise_a2b |=> $stable(st_r.a2b_store);
  endproperty
  a_a2b_hold: assert property (p_a2b_hold)
    else $error("a_to_b store changed without a capture edge");

  property p_b2a_independent;
    rise_a2b && !rise_b2a |=> $stable(st_r.b2a_store);
  endproperty
  a_b2a_independent: assert property (p_b2a_independent)
    else $error("b_to_a store followed the other capture clock");

  property p_a2b_capture;
    s_a2b_rise |=> st_r.a2b_store == $past(a_live);
  endproperty
  a_a2b_capture: assert property (p_a2b_capture)
    else $error("a_to_b store missed the A lines");

  property p_b2a_capture;
    rise_b2a |=> st_r.b2a_store == $past(b_live);
  endproperty
  a_b2a_capture: assert property (p_b2a_capture)
    else $error("b_to_a store missed the B lines");

  property p_isolated;
    st_r.oe_n |=> port_a_lines_oe == '0 && port_b_lines_oe == '0;
  endproperty
  a_isolated: assert property (p_isolated)
    else $error("a bus is driven while outputs are disabled");

  property p_dir_ignored;
    st_r.oe_n && $changed(st_r.dir) |=> !st_r.a_drv && !st_r.b_drv;
  endproperty
  a_dir_ignored: assert property (p_dir_ignored)
    else $error("direction change drove a bus while disabled");

  property p_live_to_a;
    drive_a && !st_r.b2a_sel |=> st_r.a_drv && port_a_lines_o == $past(b_live);
  endproperty
  a_live_to_a: assert property (p_live_to_a)
    else $error("A bus does not carry live B data");

  property p_stored_to_a;
    drive_a && st_r.b2a_sel |=> st_r.a_drv && port_a_lines_o == $past(st_r.b2a_store);
  endproperty
  a_stored_to_a: assert property (p_stored_to_a)
    else $error("A bus does not carry the b_to_a store");

  property p_live_to_b;
    drive_b && !st_r.a2b_sel |=> st_r.b_drv && port_b_lines_o == $past(a_live);
  endproperty
  a_live_to_b: assert property (p_live_to_b)
    else $error("B bus does not carry live A data");

  property p_stored_to_b;
    drive_b && st_r.a2b_sel |=> st_r.b_drv && port_b_lines_o == $past(st_r.a2b_store);
  endproperty
  a_stored_to_b: assert property (p_stored_to_b)
    else $error("B bus does not carry the a_to_b store");

  property p_isolated_capture;
    s_isolated_rise |=> st_r.a2b_store == $past(a_live) && st_r.b2a_store == $past(b_live);
  endproperty
  a_isolated_capture: assert property (p_isolated_capture)
    else $error("capture lost while outputs are disabled");

  property p_transceive_capture;
    s_drive_b_both_rise |=> st_r.a2b_store == $past(a_live) ##1 st_r.b_drv;
  endproperty
  a_transceive_capture: assert property (p_transceive_capture)
    else $error("non-driven port data not stored while transceiving");

  property p_one_bus;
    !(port_a_lines_oe != '0 && port_b_lines_oe != '0);
  endproperty
  a_one_bus: assert property (p_one_bus)
    else $error("both buses driven at once");

  property p_reset_state;
    @(posedge aclk) disable iff (1'b0)
      !aresetn |=> st_r.a2b_store == '0 && st_r.b2a_store == '0 &&
        port_a_lines_oe == '0 && port_b_lines_oe == '0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset left a bus driven or a store set");

endmodule

`default_nettype wire

// File: rtl/orbt_sync_note_placeholder.sv
`default_nettype none
`default_nettype wire

// File: verification/orbt_agents.sv
`default_nettype none

module orbt_agents
  import orbt_pkg::*;
(
  input wire logic [orbt_pkg::BUS_W-1:0] a_src,
  input wire logic [orbt_pkg::BUS_W-1:0] b_src,
  input wire logic [orbt_pkg::BUS_W-1:0] a_o,
  input wire logic [orbt_pkg::BUS_W-1:0] a_oe,
  input wire logic [orbt_pkg::BUS_W-1:0] b_o,
  input wire logic [orbt_pkg::BUS_W-1:0] b_oe,
  output logic [orbt_pkg::BUS_W-1:0] a_wire,
  output logic [orbt_pkg::BUS_W-1:0] b_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bus agents
  // ****
  // each agent backs off bit by bit wherever the device drives, so no fight
  always_comb begin
    for (int i = 0; i < BUS_W; i++) begin
      a_wire[i] = a_oe[i] ? a_o[i] : a_src[i];
      b_wire[i] = b_oe[i] ? b_o[i] : b_src[i];
    end
  end
endmodule

`default_nettype wire

// File: verification/tb_top.sv
`default_nettype none

module tb_top;
  import orbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, clk_ab, clk_ba;
  logic [3:0] awaddr, araddr, wstrb, ctrl;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp;
  logic [7:0] a_src, b_src, a_o, a_oe, b_o, b_oe, a_w, b_w, st_a, st_b;
  int n_errors, tests_run;

  orbt_xcvr dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .a_to_b_capture_clock(clk_ab),
    .b_to_a_capture_clock(clk_ba), .port_a_lines_i(a_w), .port_a_lines_o(a_o),
    .port_a_lines_oe(a_oe), .port_b_lines_i(b_w), .port_b_lines_o(b_o),
    .port_b_lines_oe(b_oe)
  );

  orbt_agents agents_u (
    .a_src(a_src), .b_src(b_src), .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
    .a_wire(a_w), .b_wire(b_w)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****
  // reference model
  // ****
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic drv(input logic side_b);
    return !ctrl[CTRL_OE_N_BIT] && (ctrl[CTRL_DIR_BIT] == side_b);
  endfunction

  function logic [7:0] ea();
    return drv(1'b0) ? (ctrl[CTRL_B2A_SEL_BIT] ? st_b : b_src) : a_src;
  endfunction

  function logic [7:0] eb();
    return drv(1'b1) ? (ctrl[CTRL_A2B_SEL_BIT] ? st_a : a_src) : b_src;
  endfunction

  function logic [31:0] ex(input logic [3:0] ad);
    case (ad)
      CTRL_OFS: return {28'h0, ctrl};
      STORE_OFS: return {drv(1'b1), drv(1'b0), 6'h0, st_b, 8'h0, st_a};
      LIVE_OFS: return {8'h0, eb(), 8'h0, ea()};
      default: return 32'h0;
    endcase
  endfunction

  // ****
  // bench tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up();
    $display("counts: %0d compared, %0d mismatched", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task wr(input logic [3:0] ad, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] rsp;
    int n;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      n_errors++;
      wrap_up();
    end
    chk({30'h0, rsp}, {30'h0, (ad == 4'hc) ? RESP_SLVERR : RESP_OKAY});
    if (ad == CTRL_OFS && wstrb[0]) ctrl = d[3:0];
  endtask

  task rd(input logic [3:0] ad);
    logic ta, tr;
    logic [31:0] dat;
    logic [1:0] rsp;
    int n;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      dat = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      n_errors++;
      wrap_up();
    end
    chk(dat, ex(ad));
    chk({30'h0, rsp}, {30'h0, (ad == 4'hc) ? RESP_SLVERR : RESP_OKAY});
  endtask

  // settle, then compare both wires and enables with the model
  task look();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk({24'h0, a_w}, {24'h0, ea()});
    chk({24'h0, b_w}, {24'h0, eb()});
    chk({24'h0, a_oe}, {24'h0, {8{drv(1'b0)}}});
    chk({24'h0, b_oe}, {24'h0, {8{drv(1'b1)}}});
    rd(CTRL_OFS);
    rd(STORE_OFS);
    rd(LIVE_OFS);
  endtask

  task pins();
    logic [31:0] r;
    r = rnd();
    @(posedge aclk);
    a_src <= r[7:0];
    b_src <= r[15:8];
    repeat (6) @(posedge aclk);
  endtask

  // clock pins stay high and low for 4 cycles each, above the 3 needed
  task cap(input logic ab, input logic ba);
    logic [7:0] na, nb;
    na = ea();
    nb = eb();
    @(posedge aclk);
    clk_ab <= ab;
    clk_ba <= ba;
    repeat (4) @(posedge aclk);
    clk_ab <= 1'b0;
    clk_ba <= 1'b0;
    if (ab) st_a = na;
    if (ba) st_b = nb;
    repeat (4) @(posedge aclk);
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    seed = 32'hc477a48a;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clk_ab, clk_ba} = 8'h00;
    {awaddr, araddr, wdata, a_src, b_src} = 56'h0;
    wstrb = 4'hf;
    ctrl = CTRL_RESET;
    st_a = STORE_RESET;
    st_b = STORE_RESET;
    n_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    look();
    $display("test reset state done");
    wr(4'hc, 32'h0000000e);
    rd(4'hc);
    wr(STORE_OFS, 32'hffffffff);
    // byte 0 strobe low: control must keep its value
    wstrb <= 4'he;
    wr(CTRL_OFS, 32'h00000000);
    wstrb <= 4'hf;
    look();
    $display("test unmapped and read-only done");
    pins();
    cap(1'b1, 1'b1);
    look();
    wr(CTRL_OFS, 32'h0000000f);
    pins();
    cap(1'b1, 1'b0);
    look();
    $display("test isolation done");
    for (int m = 0; m < 8; m++) begin
      wr(CTRL_OFS, {28'h0, m[2:0], 1'b0});
      pins();
      look();
      // both clocks rise together in some modes of each direction
      cap(m[0] | m[1], !m[0] | m[2]);
      look();
      pins();
      look();
    end
    $display("test drive modes done");
    // reset in mid-run: stores cleared, outputs released, capture clocks stay low
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ctrl = CTRL_RESET;
    st_a = STORE_RESET;
    st_b = STORE_RESET;
    look();
    $display("test mid-run reset done");
    wr(CTRL_OFS, 32'h00000001);
    look();
    $display("test disable done");
    wrap_up();
  end
endmodule

`default_nettype wire
